// File: hw/emergency_run_override.sv
/*
 * Emergency-run override of a motor drive: arming, trigger, forced run,
 * trip masking, undervoltage derating, automatic trip reset and restart,
 * activation stamp and count, with a classic Wishbone register slave.
 * Assumes the trip sources, command word and drive status come from logic on
 * clk_i; the trigger and safe torque cutoff come from pins.
 */
// Register access over Wishbone and the register offsets are this design's own decisions.
// How it works
// - Active when armed and trigger is true.
// - Armed when level enabled and reference nonzero.
// - Level codes 0,1,2; disabled after reset.
// - Trigger only from input pin; false after reset.
// - Signed reference within plus/minus full scale.
// - Active selects emergency reference through ramp.
// - Ramp freeze still honoured during override.
// - Override replaces sequencing and commands run.
// - Only listed causes stop the forced run.
// - Restart wait sets delay before trip reset.
// - Partial level masks the listed application trips.
// - Full level also masks drive-protection trips.
// - Trips 1,3,4,5,27 are never masked.
// - Undervoltage stays enabled, threshold halved.
// - Masked protection trips keep running, get logged.
// - Enabled trip stops, then reset and restart.
// - Activation stamps time; cleared on foreign application.
// - Activation count increments; cleared on foreign application.
// - Deactivation returns to previous sequencing source.
// - Activation starts drive unless already running.
`timescale 1ns/1ps
`include "emergency_run_regs.svh"

module emergency_run_override #(
    parameter int MS_CYCLES = `ER_MS_CYCLES
) (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Pins
    input wire logic trigger_pin_i,
    input wire logic safe_torque_cutoff_i,
    // Drive logic inputs
    input wire logic switch_on_i,
    input wire logic hw_fault_i,
    input wire logic [27:1] trip_src_i,
    input wire logic ramp_hold_i,
    input wire logic remote_mode_i,
    input wire logic remote_run_i,
    input wire logic local_run_i,
    input wire logic drive_running_i,
    input wire logic app_no_override_i,
    input wire logic [31:0] rtc_time_i,
    input wire logic [15:0] uv_thresh_i,
    // Drive control outputs
    output logic armed_o,
    output logic active_o,
    output logic run_cmd_o,
    output logic start_o,
    output logic trip_reset_o,
    output logic ref_select_o,
    output logic [15:0] ref_o,
    output logic ramp_hold_o,
    output logic [27:1] trip_mask_o,
    output logic [15:0] uv_thresh_o,
    output logic hist_log_o,
    output logic [4:0] hist_id_o
);
    localparam logic [27:0] PROT = `ER_DRIVE_PROT;

    override_if oif ();

    emergency_run_pkg::level_e level_r;
    logic [15:0] ref_r;
    logic [15:0] wait_r;
    logic [31:0] stamp_r;
    logic [31:0] count_r;
    logic [4:0] last_hist_r;
    emergency_run_pkg::seq_e state_r;
    emergency_run_pkg::seq_e state_nxt;
    logic [2:0] trig_sync_r;
    logic [2:0] sto_sync_r;
    logic trigger_r;
    logic sto_r;
    logic active_r;
    logic local_block_r;
    logic [27:0] src_q_r;
    logic ack_r;
    logic [31:0] rdata_r;

    logic bus_req;
    logic bus_wr;
    logic [27:0] src_vec;
    logic enabled_trip;
    logic armed;
    logic active;
    logic [27:0] log_rise;
    logic [4:0] log_id;
    logic restart;
    logic run_nxt;
    logic [15:0] ref_nxt;
    logic [15:0] wait_nxt;

    // ======================================================================
    // Submodules
    // ======================================================================
    trip_mask u_mask (
        .mif(oif.mask_mp)
    );

    restart_timer #(
        .MS_CYCLES(MS_CYCLES)
    ) u_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .tif(oif.timer_mp)
    );

    assign oif.level = level_r;
    assign oif.wait_ms = wait_r;

    // ======================================================================
    // Pin synchronisers: a change counts once stages two and three agree.
    // ======================================================================
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trig_sync_r <= 3'h0;
            sto_sync_r <= 3'h0;
            trigger_r <= 1'b0;
            sto_r <= 1'b0;
        end else if (ce_i) begin
            trig_sync_r <= {trig_sync_r[1:0], trigger_pin_i};
            sto_sync_r <= {sto_sync_r[1:0], safe_torque_cutoff_i};
            if (trig_sync_r[1] == trig_sync_r[2]) begin
                trigger_r <= trig_sync_r[2];
            end
            if (sto_sync_r[1] == sto_sync_r[2]) begin
                sto_r <= sto_sync_r[2];
            end
        end
    end

    // ======================================================================
    // Arming, activation and trip evaluation.
    // ======================================================================
    assign armed = (level_r != emergency_run_pkg::lvl_disabled) && (ref_r != 16'h0000);
    assign active = armed && trigger_r;
    assign src_vec = {trip_src_i, 1'b0};
    // Undervoltage (ID 2) is never in the mask, so it always counts here.
    assign enabled_trip = |(src_vec & ~oif.mask);
    assign log_rise = src_vec & ~src_q_r & oif.mask & PROT;

    // Lowest ID wins when several protection trips rise in one cycle.
    always_comb begin
        log_id = 5'h00;
        for (int i = 27; i >= 1; i--) begin
            if (log_rise[i]) begin
                log_id = 5'(i);
            end
        end
    end

    // ======================================================================
    // Sequencing state machine for the forced run.
    // ======================================================================
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            emergency_run_pkg::st_idle: begin
                if (active) begin
                    state_nxt = emergency_run_pkg::st_run;
                end
            end
            emergency_run_pkg::st_run: begin
                if (!active) begin
                    state_nxt = emergency_run_pkg::st_idle;
                end else if (enabled_trip) begin
                    state_nxt = emergency_run_pkg::st_tripped;
                end
            end
            emergency_run_pkg::st_tripped: begin
                if (!active) begin
                    state_nxt = emergency_run_pkg::st_idle;
                end else if (!enabled_trip) begin
                    state_nxt = emergency_run_pkg::st_wait;
                end
            end
            emergency_run_pkg::st_wait: begin
                if (!active) begin
                    state_nxt = emergency_run_pkg::st_idle;
                end else if (enabled_trip) begin
                    state_nxt = emergency_run_pkg::st_tripped;
                end else if (oif.tmr_expired) begin
                    state_nxt = emergency_run_pkg::st_run;
                end
            end
            default: begin
                state_nxt = emergency_run_pkg::st_idle;
            end
        endcase
    end

    assign oif.tmr_start = ce_i && (state_r == emergency_run_pkg::st_tripped) && active && !enabled_trip;
    assign oif.tmr_cancel = ce_i && (state_r == emergency_run_pkg::st_wait) && (!active || enabled_trip);
    assign restart = (state_r == emergency_run_pkg::st_wait) && active && !enabled_trip && oif.tmr_expired;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= emergency_run_pkg::st_idle;
        end else if (ce_i) begin
            state_r <= state_nxt;
        end
    end

    // Run command: forced while active, else the previous source.
    always_comb begin
        if (active) begin
            run_nxt = (state_r == emergency_run_pkg::st_run) && switch_on_i && !sto_r && !hw_fault_i;
        end else if (remote_mode_i) begin
            run_nxt = remote_run_i;
        end else begin
            // The stop latch sets one cycle late, so the falling cycle is blocked too.
            run_nxt = local_run_i && !local_block_r && !active_r;
        end
    end

    // ======================================================================
    // Local-mode stop latch: deactivation stops until local run is dropped.
    // ======================================================================
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            local_block_r <= 1'b0;
            active_r <= 1'b0;
            src_q_r <= 28'h0000000;
        end else if (ce_i) begin
            active_r <= active;
            src_q_r <= src_vec;
            if (active_r && !active && !remote_mode_i) begin
                local_block_r <= 1'b1;
            end else if (!local_run_i) begin
                local_block_r <= 1'b0;
            end
        end
    end

    // ======================================================================
    // Drive control outputs, all registered.
    // ======================================================================
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            armed_o <= 1'b0;
            active_o <= 1'b0;
            run_cmd_o <= 1'b0;
            start_o <= 1'b0;
            trip_reset_o <= 1'b0;
            ref_select_o <= 1'b0;
            ref_o <= `ER_REF_RESET;
            ramp_hold_o <= 1'b0;
            trip_mask_o <= 27'h0000000;
            uv_thresh_o <= 16'h0000;
            hist_log_o <= 1'b0;
            hist_id_o <= 5'h00;
        end else if (ce_i) begin
            armed_o <= armed;
            active_o <= active;
            run_cmd_o <= run_nxt;
            // Start on activation of a stopped drive, and in the same cycle as each auto reset.
            start_o <= (active && !active_r && !drive_running_i) || restart;
            trip_reset_o <= restart;
            ref_select_o <= active;
            ref_o <= ref_r;
            // Freeze passes straight on so the ramp may still hold the reference.
            ramp_hold_o <= ramp_hold_i;
            trip_mask_o <= active ? oif.mask[27:1] : 27'h0000000;
            // Halving keeps the trip live while tolerating sag during the run.
            uv_thresh_o <= active ? {1'b0, uv_thresh_i[15:1]} : uv_thresh_i;
            hist_log_o <= active && (log_rise != 28'h0000000);
            if (active && (log_rise != 28'h0000000)) begin
                hist_id_o <= log_id;
            end
        end
    end

    // ======================================================================
    // Non-volatile image: stamp and count. Activation wins over a clear.
    // ======================================================================
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stamp_r <= 32'h00000000;
            count_r <= 32'h00000000;
            last_hist_r <= 5'h00;
        end else if (ce_i) begin
            if (active && !active_r) begin
                stamp_r <= rtc_time_i;
                count_r <= count_r + 32'h00000001;
            end else if (app_no_override_i) begin
                stamp_r <= 32'h00000000;
                count_r <= 32'h00000000;
            end
            if (active && (log_rise != 28'h0000000)) begin
                last_hist_r <= log_id;
            end
        end
    end

    // ======================================================================
    // Wishbone slave: one wait state, ack pulses one cycle.
    // ======================================================================
    assign bus_req = wb_cyc_i && wb_stb_i && !ack_r;
    // A write lands at the edge where the master samples ack high.
    assign bus_wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_r;
    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdata_r;

    // Byte lanes merge before the reference is clamped to full scale.
    always_comb begin
        ref_nxt = ref_r;
        if (wb_sel_i[0]) begin
            ref_nxt[7:0] = wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
            ref_nxt[15:8] = wb_dat_i[15:8];
        end
        if ($signed(ref_nxt) > $signed(`ER_REF_MAX)) begin
            ref_nxt = `ER_REF_MAX;
        end else if ($signed(ref_nxt) < $signed(`ER_REF_MIN)) begin
            ref_nxt = `ER_REF_MIN;
        end
        wait_nxt = wait_r;
        if (wb_sel_i[0]) begin
            wait_nxt[7:0] = wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
            wait_nxt[15:8] = wb_dat_i[15:8];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            level_r <= emergency_run_pkg::lvl_disabled;
            ref_r <= `ER_REF_RESET;
            wait_r <= `ER_WAIT_RESET;
        end else if (ce_i && bus_wr) begin
            case (wb_adr_i)
                `ER_ADR_LEVEL: begin
                    // Code 3 is not a level; such a write is ignored.
                    if (wb_sel_i[0] && (wb_dat_i[1:0] != 2'h3)) begin
                        level_r <= emergency_run_pkg::level_e'(wb_dat_i[1:0]);
                    end
                end
                `ER_ADR_REF: begin
                    ref_r <= ref_nxt;
                end
                `ER_ADR_WAIT: begin
                    wait_r <= wait_nxt;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            rdata_r <= 32'h00000000;
        end else if (ce_i) begin
            ack_r <= bus_req;
            rdata_r <= 32'h00000000;
            if (bus_req && !wb_we_i) begin
                case (wb_adr_i)
                    `ER_ADR_LEVEL: rdata_r <= {30'h00000000, level_r};
                    `ER_ADR_REF: rdata_r <= {{16{ref_r[15]}}, ref_r};
                    `ER_ADR_WAIT: rdata_r <= {16'h0000, wait_r};
                    `ER_ADR_STATUS: begin
                        rdata_r[`ER_ST_ARMED] <= armed;
                        rdata_r[`ER_ST_ACTIVE] <= active;
                        rdata_r[`ER_ST_TRIPPED] <= (state_r == emergency_run_pkg::st_tripped);
                        rdata_r[`ER_ST_WAITING] <= (state_r == emergency_run_pkg::st_wait);
                        rdata_r[`ER_ST_RUN] <= run_cmd_o;
                        rdata_r[`ER_ST_TRIGGER] <= trigger_r;
                    end
                    `ER_ADR_STAMP: rdata_r <= stamp_r;
                    `ER_ADR_COUNT: rdata_r <= count_r;
                    `ER_ADR_HIST: rdata_r <= {27'h0000000, last_hist_r};
                    default: rdata_r <= 32'h00000000;
                endcase
            end
        end
    end
endmodule : emergency_run_override

// File: hw/emergency_run_pkg.sv
/*
 * Types shared by the emergency-run override modules.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package emergency_run_pkg;

    // ======================================================================
    // Protection level and sequencing states
    typedef enum logic [1:0] {
        lvl_disabled = 2'h0,
        lvl_partial = 2'h1,
        lvl_full = 2'h2
    } level_e;

    typedef enum logic [1:0] {
        st_idle = 2'h0,
        st_run = 2'h1,
        st_tripped = 2'h3,
        st_wait = 2'h2
    } seq_e;

endpackage : emergency_run_pkg

// File: hw/emergency_run_regs.svh
/*
 * Register offsets, reset values, trip tables and timing counts of the
 * emergency-run override.
 * Assumes it is included by bare name from the design modules.
 */
`ifndef EMERGENCY_RUN_REGS_SVH
`define EMERGENCY_RUN_REGS_SVH

// ==========================================================================
// Register map (byte addresses on the Wishbone slave)
`define ER_ADR_LEVEL 8'h00
`define ER_ADR_REF 8'h04
`define ER_ADR_WAIT 8'h08
`define ER_ADR_STATUS 8'h0c
`define ER_ADR_STAMP 8'h10
`define ER_ADR_COUNT 8'h14
`define ER_ADR_HIST 8'h18

// ==========================================================================
// Reset values and limits
`define ER_REF_RESET 16'h0000
`define ER_REF_MAX 16'h03e8
`define ER_REF_MIN 16'hfc18
`define ER_WAIT_RESET 16'h0000

// ==========================================================================
// Status register fields
`define ER_ST_ARMED 0
`define ER_ST_ACTIVE 1
`define ER_ST_TRIPPED 2
`define ER_ST_WAITING 3
`define ER_ST_RUN 4
`define ER_ST_TRIGGER 5

// ==========================================================================
// Trip tables, bit index equals trip ID, bit 0 unused
`define ER_MASK_PARTIAL 28'h7bd66c0
`define ER_MASK_FULL_EXTRA 28'h0429900
`define ER_DRIVE_PROT 28'h042993a

// ==========================================================================
// Timing
`define ER_CLK_PERIOD_NS 50
`define ER_MS_NS 1000000
`define ER_MS_CYCLES (`ER_MS_NS / `ER_CLK_PERIOD_NS)

`endif

// File: hw/override_if.sv
/*
 * Interface joining the override top to its trip mask table and its
 * restart timer.
 * Assumes both sides run on the top's clock.
 */
`timescale 1ns/1ps

interface override_if;
    emergency_run_pkg::level_e level;
    logic [27:0] mask;
    logic tmr_start;
    logic tmr_cancel;
    logic [15:0] wait_ms;
    logic tmr_expired;

    modport mask_mp (input level, output mask);
    modport timer_mp (input tmr_start, input tmr_cancel, input wait_ms, output tmr_expired);
    modport top_mp (output level, input mask, output tmr_start, output tmr_cancel, output wait_ms,
        input tmr_expired);
endinterface : override_if

// File: hw/restart_timer.sv
/*
 * Millisecond countdown that gates the automatic trip reset.
 * Assumes start and cancel are single-cycle strobes from the top.
 */
`timescale 1ns/1ps

module restart_timer #(
    parameter int MS_CYCLES = 20000
) (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Timer control
    override_if.timer_mp tif
);
    localparam int PW = $clog2(MS_CYCLES + 1);
    localparam logic [PW-1:0] PRE_LAST = PW'(MS_CYCLES - 1);

    logic busy_r;
    logic [15:0] remain_r;
    logic [PW-1:0] pre_r;
    logic expired_r;

    assign tif.tmr_expired = expired_r;

    // ======================================================================
    // Countdown: a start loads the wait, zero remaining fires one pulse.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_r <= 1'b0;
            remain_r <= 16'h0000;
            pre_r <= '0;
            expired_r <= 1'b0;
        end else if (ce_i) begin
            expired_r <= 1'b0;
            if (tif.tmr_start) begin
                busy_r <= 1'b1;
                remain_r <= tif.wait_ms;
                pre_r <= '0;
            end else if (tif.tmr_cancel) begin
                busy_r <= 1'b0;
            end else if (busy_r) begin
                if (remain_r == 16'h0000) begin
                    busy_r <= 1'b0;
                    expired_r <= 1'b1;
                end else if (pre_r == PRE_LAST) begin
                    pre_r <= '0;
                    remain_r <= remain_r - 16'h0001;
                end else begin
                    pre_r <= pre_r + 1'b1;
                end
            end
        end
    end
endmodule : restart_timer

// File: hw/trip_mask.sv
/*
 * Level-dependent trip mask table.
 * Assumes the level is already a stored value; output is combinational.
 */
`timescale 1ns/1ps
`include "emergency_run_regs.svh"

module trip_mask (
    // Level in, mask out
    override_if.mask_mp mif
);
    localparam logic [27:0] PART = `ER_MASK_PARTIAL;
    localparam logic [27:0] FULLX = `ER_MASK_FULL_EXTRA;

    // ======================================================================
    // One table entry per trip ID
    genvar i;
    generate
        for (i = 0; i < 28; i++) begin : g_bit
            // IDs 1, 3, 4, 5, 27 and 2 have no bit in either table.
            assign mif.mask[i] = ((mif.level == emergency_run_pkg::lvl_partial) && PART[i]) ||
                ((mif.level == emergency_run_pkg::lvl_full) && (PART[i] || FULLX[i]));
        end
    endgenerate
endmodule : trip_mask

// File: sim/emergency_run_override_bench.sv
/* Self-checking bench of the emergency-run override.
   Assumes the design and the checker are compiled before it. */
`timescale 1ns/1ps

module emergency_run_override_bench;
    // ======================================================================
    // Ports and bookkeeping
    logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd, rtc_time_i = 32'h0;
    logic [3:0] wb_sel_i = 4'hf;
    logic trigger_pin_i = 1'b0, safe_torque_cutoff_i = 1'b0, switch_on_i = 1'b1, hw_fault_i = 1'b0;
    logic ramp_hold_i = 1'b0, remote_mode_i = 1'b0, remote_run_i = 1'b0, local_run_i = 1'b0;
    logic drive_running_i = 1'b0, app_no_override_i = 1'b0, start_seen = 1'b0, reset_seen = 1'b0;
    logic [27:1] trip_src_i = 27'h0, trip_mask_o;
    logic [15:0] uv_thresh_i = 16'h0, ref_o, uv_thresh_o;
    logic wb_ack_o, armed_o, active_o, run_cmd_o, start_o, trip_reset_o, ref_select_o, ramp_hold_o, hist_log_o;
    logic [4:0] hist_id_o;
    int failures = 0, check_count = 0;
    typedef struct packed {logic [1:0] lvl; logic [15:0] refv; logic armed;} row_s;
    row_s rows [4] = '{'{2'h0, 16'h0064, 1'b0}, '{2'h2, 16'h0000, 1'b0}, '{2'h1, 16'hfff6, 1'b1},
        '{2'h2, 16'h0064, 1'b1}};

    // A short millisecond keeps the restart wait within a few cycles.
    emergency_run_override #(.MS_CYCLES(4)) emergency_run_override_i (.*);

    // Clock, and a catch for one-cycle pulses that fall between checks.
    initial forever #25 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        if (start_o === 1'b1) start_seen <= 1'b1;
        if (trip_reset_o === 1'b1) reset_seen <= 1'b1;
    end

    // ======================================================================
    // Tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One classic cycle; the request stands until ack is sampled high.
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        n = 0;
        do begin @(posedge clk_i); n++; end while (wb_ack_o !== 1'b1 && n < 20);
        chk(wb_ack_o, 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rchk

    task automatic tally_and_finish();
        $display("checks=%0d failures=%0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : tally_and_finish

    // ======================================================================
    // Tests
    // ======================================================================
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (rows[i]) begin
            wb(1'b1, 8'h00, {30'h0, rows[i].lvl});
            wb(1'b1, 8'h04, {16'h0, rows[i].refv});
            repeat (2) @(posedge clk_i);
            chk(armed_o, rows[i].armed);
            rchk(8'h04, {{16{rows[i].refv[15]}}, rows[i].refv});
        end
        // A mid-run reset must bring back the idle values.
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rchk(8'h00, 32'h0);
        rchk(8'h04, 32'h0);
        chk(armed_o, 1'b0);
        $display("rows and reset done");
        rtc_time_i <= 32'h12345678;
        uv_thresh_i <= 16'h0200;
        wb(1'b1, 8'h04, 32'h00000500);
        rchk(8'h04, 32'h000003e8);
        wb(1'b1, 8'h04, 32'h00000064);
        wb(1'b1, 8'h08, 32'h00000001);
        wb(1'b1, 8'h00, 32'h00000001);
        wb(1'b1, 8'h00, 32'h00000003);
        rchk(8'h00, 32'h1);
        trigger_pin_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        chk(active_o, 1'b1);
        chk(start_seen, 1'b1);
        chk(ref_o, 16'h0064);
        chk(ref_select_o, 1'b1);
        chk(trip_mask_o, 27'h3deb360);
        chk(run_cmd_o, 1'b1);
        chk(uv_thresh_o, 16'h0100);
        rchk(8'h10, 32'h12345678);
        rchk(8'h14, 32'h1);
        wb(1'b1, 8'h00, 32'h2);
        trip_src_i <= 27'h0002080;
        repeat (3) @(posedge clk_i);
        chk(trip_mask_o, 27'h3ffffe0);
        chk(run_cmd_o, 1'b1);
        chk(hist_id_o, 5'h08);
        trip_src_i <= 27'h0000004;
        repeat (3) @(posedge clk_i);
        chk(run_cmd_o, 1'b0);
        trip_src_i <= 27'h0;
        reset_seen <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk(reset_seen, 1'b0);
        repeat (8) @(posedge clk_i);
        chk(reset_seen, 1'b1);
        chk(run_cmd_o, 1'b1);
        $display("trip test done");
        hw_fault_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk(run_cmd_o, 1'b0);
        hw_fault_i <= 1'b0;
        safe_torque_cutoff_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        chk(run_cmd_o, 1'b0);
        safe_torque_cutoff_i <= 1'b0;
        ramp_hold_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        chk(ramp_hold_o, 1'b1);
        local_run_i <= 1'b1;
        trigger_pin_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        chk(run_cmd_o, 1'b0);
        app_no_override_i <= 1'b1;
        @(posedge clk_i);
        app_no_override_i <= 1'b0;
        rchk(8'h14, 32'h0);
        $display("stop test done");
        tally_and_finish();
    end

    // The tests need some 140 cycles; 3000 leaves ample margin.
    initial begin
        repeat (3000) @(posedge clk_i);
        failures++;
        tally_and_finish();
    end
endmodule : emergency_run_override_bench

// File: sim/er_assertions.sv
/* Port checker for the emergency-run override.
   Assumes binding to the top module, one clock, ce_i high in normal use. */
`timescale 1ns/1ps

module er_assertions (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Watched ports
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic trigger_pin_i,
    input wire logic switch_on_i,
    input wire logic hw_fault_i,
    input wire logic [15:0] uv_thresh_i,
    input wire logic armed_o,
    input wire logic active_o,
    input wire logic run_cmd_o,
    input wire logic [27:1] trip_mask_o,
    input wire logic [15:0] uv_thresh_o
);
    // ======================================================================
    // Properties
    // A low enable freezes every relation, so it disables the checks too.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i || !ce_i);
    sequence req_s; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    sequence arm_trig_s; armed_o && trigger_pin_i; endsequence
    bus_answer_a: assert property (req_s |=> wb_ack_o) else $error("request not acked");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    armed_gate_a: assert property (active_o |-> armed_o) else $error("active while unarmed");
    trigger_act_a: assert property (arm_trig_s [*7] |-> active_o) else $error("trigger ignored");
    mask_off_a: assert property (!active_o |-> trip_mask_o == 27'h0) else $error("mask while idle");
    partial_set_a: assert property (active_o |-> ({trip_mask_o, 1'b0} & 28'h7bd66c0) == 28'h7bd66c0)
        else $error("partial set incomplete");
    keep_on_a: assert property ({trip_mask_o[27], trip_mask_o[5:1]} == 6'h00) else $error("kept trip masked");
    uv_half_a: assert property (active_o |-> uv_thresh_o == ($past(uv_thresh_i) >> 1))
        else $error("undervoltage not halved");
    stop_cause_a: assert property (active_o && !($past(switch_on_i) && !$past(hw_fault_i)) |-> !run_cmd_o)
        else $error("ran through stop");
endmodule : er_assertions

bind emergency_run_override er_assertions er_assertions_i (.*);
